// *** verilog/icss_consts.svh ***
// character codes, field positions and counts of the call signal sequencer
`ifndef ICSS_CONSTS_SVH
`define ICSS_CONSTS_SVH

`define ICSS_CHAR_W 8
`define ICSS_CH_DIGIT_HI 4'h3
`define ICSS_CH_PROG 8'h3a
`define ICSS_CH_NETID 8'h3b
`define ICSS_CH_TERM12 8'h3c
`define ICSS_CH_GO 8'h3d
`define ICSS_CH_CLEAR 8'h3f
`define ICSS_CH_END_SEL 8'h2b
`define ICSS_CODE_DIGITS 4
`define ICSS_CC_DIGITS 3
`define ICSS_NET_DIGIT_LSB 0
`define ICSS_PROG_LAST_IDX 2
`define ICSS_MAX_DIGITS 15
`define ICSS_BITS_PER_CHAR 4'h8

`endif

// *** verilog/icss_pkg.sv ***
// types and the digit encoder shared by the call signal sequencer
`default_nettype none
package icss_pkg;
    typedef logic [7:0] icss_char_t;
    typedef enum logic [2:0] {
        SEG_SEL, SEG_NETID, SEG_CALLED, SEG_CALLING, SEG_PROG, SEG_GO,
        SEG_CLEAR
    } icss_seg_e;
    typedef enum logic [3:0] {
        ST_IDLE, ST_SEL, ST_NETID, ST_PROG1, ST_CALLED, ST_CALLING,
        ST_WAIT, ST_GO, ST_PROGC, ST_CLEAR, ST_THRU
    } icss_state_e;

    function automatic icss_char_t dchar(input logic [3:0] d);
        return {4'h3, d};
    endfunction
endpackage
`default_nettype wire

// *** verilog/icss_char_sel.sv ***
// picks the character for a given sequence segment and position
`include "icss_consts.svh"
`default_nettype none
module icss_char_sel #(
    parameter int MAXD = `ICSS_MAX_DIGITS,
    parameter int IW = $clog2(MAXD + 5)
) (
    // position
    input wire icss_pkg::icss_seg_e i_seg,
    input wire logic [IW-1:0] i_idx,
    // call data
    input wire logic [15:0] i_net_code,
    input wire logic i_suppress_cc,
    input wire logic i_called_avail,
    input wire logic [IW-1:0] i_called_len,
    input wire logic [4*MAXD-1:0] i_called_num,
    input wire logic i_calling_avail,
    input wire logic [IW-1:0] i_calling_len,
    input wire logic [4*MAXD-1:0] i_calling_num,
    input wire logic [7:0] i_prog_num,
    // result
    output logic [7:0] o_char,
    output logic o_last
);
    // digit j of a number, most significant first; beyond MAXD reads 0
    function automatic logic [3:0] pick(input logic [4*MAXD-1:0] v,
                                        input logic [IW:0] j);
        logic [3:0] r;
        r = 4'h0;
        for (int k = 0; k < MAXD; k++) begin
            if (j == (IW+1)'(k)) begin
                r = v[4*(MAXD-1-k) +: 4];
            end
        end
        return r;
    endfunction

    function automatic logic [3:0] code_dig(input logic [15:0] c,
                                            input logic [1:0] k);
        return c[4*(3-k) +: 4];
    endfunction

    logic [IW:0] ix;
    logic [IW:0] ncode;
    logic [IW:0] nlen;
    logic [IW:0] rel;
    logic [4*MAXD-1:0] num;

    always_comb begin
        ix = {1'b0, i_idx};
        ncode = (IW+1)'(`ICSS_CODE_DIGITS);
        nlen = {1'b0, i_called_len};
        rel = ix - ncode;
        num = i_called_num;
        o_char = `ICSS_CH_CLEAR;
        o_last = 1'b0;
        case (i_seg)
            icss_pkg::SEG_SEL: begin
                // terminal call may drop the country part [R10]
                if (i_suppress_cc) begin
                    ncode = (IW+1)'(1);
                end
                rel = ix - ncode;
                if (ix < ncode) begin
                    o_char = icss_pkg::dchar(i_suppress_cc ?
                        i_net_code[`ICSS_NET_DIGIT_LSB +: 4] :
                        code_dig(i_net_code, ix[1:0])); // [R13]
                end else if (ix < ncode + nlen) begin
                    o_char = icss_pkg::dchar(pick(num, rel)); // [R16]
                end else begin
                    o_char = `ICSS_CH_END_SEL;
                    o_last = 1'b1;
                end
            end
            icss_pkg::SEG_NETID: begin
                rel = ix - (IW+1)'(1);
                if (ix == '0) begin
                    o_char = `ICSS_CH_NETID; // [R14]
                end else begin
                    o_char = icss_pkg::dchar(code_dig(i_net_code, rel[1:0]));
                end
                o_last = (ix == ncode);
            end
            icss_pkg::SEG_CALLED, icss_pkg::SEG_CALLING: begin
                if (i_seg == icss_pkg::SEG_CALLING) begin
                    num = i_calling_num;
                    nlen = i_calling_avail ? {1'b0, i_calling_len} : '0;
                end
                if (i_seg == icss_pkg::SEG_CALLED && !i_called_avail) begin
                    o_char = `ICSS_CH_TERM12; // [R03]
                    o_last = 1'b1;
                end else if (ix < ncode) begin
                    o_char = icss_pkg::dchar(code_dig(i_net_code, ix[1:0]));
                end else if (ix < ncode + nlen) begin
                    o_char = icss_pkg::dchar(pick(num, rel)); // [R16]
                end else begin
                    o_char = `ICSS_CH_TERM12; // [R02] [R03]
                    o_last = 1'b1;
                end
            end
            icss_pkg::SEG_PROG: begin
                if (ix == '0) begin
                    o_char = `ICSS_CH_PROG; // [R01]
                end else if (ix == (IW+1)'(1)) begin
                    o_char = icss_pkg::dchar(i_prog_num[7:4]);
                end else begin
                    o_char = icss_pkg::dchar(i_prog_num[3:0]);
                    o_last = 1'b1;
                end
            end
            icss_pkg::SEG_GO: begin
                o_char = `ICSS_CH_GO;
                o_last = 1'b1;
            end
            default: begin
                o_char = `ICSS_CH_CLEAR;
                o_last = 1'b1;
            end
        endcase
    end
endmodule // icss_char_sel
`default_nettype wire

// *** verilog/icss_link_mux.sv ***
// serialises signalling characters onto the shared user data path
`include "icss_consts.svh"
`default_nettype none
module icss_link_mux (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    // character side
    input wire logic i_load,
    input wire logic [7:0] i_char,
    output logic o_ready,
    // link side
    input wire logic i_user_bit,
    output logic o_link_bit,
    output logic o_link_sig
);
    logic [7:0] sh_q, sh_d;
    logic [3:0] cnt_q, cnt_d;
    logic bit_q, bit_d;
    logic sig_q, sig_d;

    // ready one bit early so back-to-back characters leave no gap
    assign o_ready = (cnt_q == 4'h0) || (cnt_q == 4'h1);
    assign o_link_bit = bit_q;
    assign o_link_sig = sig_q;

    always_comb begin
        sh_d = sh_q;
        cnt_d = cnt_q;
        // one bit per enabled clock: the link's full rate [R07]
        if (cnt_q != 4'h0) begin
            bit_d = sh_q[0];
            sig_d = 1'b1;
            sh_d = {1'b0, sh_q[7:1]};
            cnt_d = cnt_q - 4'h1;
        end else begin
            bit_d = i_user_bit; // same path as user data [R08]
            sig_d = 1'b0;
        end
        if (i_load && o_ready) begin
            sh_d = i_char;
            cnt_d = `ICSS_BITS_PER_CHAR;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            sh_q <= 8'h00;
            cnt_q <= 4'h0;
            bit_q <= 1'b0;
            sig_q <= 1'b0;
        end else if (i_ce) begin
            sh_q <= sh_d;
            cnt_q <= cnt_d;
            bit_q <= bit_d;
            sig_q <= sig_d;
        end
    end

    chk_bit_rate: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        (i_ce && cnt_q != 4'h0) |=> (sig_q && bit_q == $past(sh_q[0])))
        else $error("signalling bit not sent at full rate"); // [R07]
    chk_user_pass: assert property (@(posedge i_sys_clk) disable iff (!i_nrst)
        (i_ce && cnt_q == 4'h0) |=> (!sig_q && bit_q == $past(i_user_bit)))
        else $error("user data not passed on the shared path"); // [R08]
endmodule // icss_link_mux
`default_nettype wire

// *** verilog/icss_sequencer.sv ***
// call control signal sequencer: builds, orders and sends call signals
// Function
// R01: progress signal is marker plus two digits
// R02: calling identity: code, digits, terminator 12
// R03: called identity likewise, else terminator alone
// R04: go signal after accept, optionally line free
// R05: cleared call: progress before or after called
// R06: cleared while waiting: progress then clearing
// R07: signalling bits at the link's full rate
// R08: signalling and user data share one path
// R09: each link's signalling built afresh here
// R10: send network code; terminal may drop country
// R11: selection sent as one contiguous block
// R12: start onward selection without delay
// R13: network code is four digits, country three
// R14: network identity is marker plus network code
// R15: reset returns idle, drops partial sequence
// R16: digits go most significant first, one slot
`include "icss_consts.svh"
`default_nettype none
module icss_sequencer #(
    parameter int MAXD = `ICSS_MAX_DIGITS,
    parameter int IW = $clog2(MAXD + 5)
) (
    // clock, reset, enable
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    // call request and options
    input wire logic i_call_req,
    input wire logic i_suppress_cc,
    input wire logic i_called_req,
    input wire logic i_calling_req,
    input wire logic i_called_avail,
    input wire logic i_calling_avail,
    input wire logic i_prog_before,
    input wire logic i_early_go,
    // identities
    input wire logic [15:0] i_net_code,
    input wire logic [IW-1:0] i_called_len,
    input wire logic [4*MAXD-1:0] i_called_num,
    input wire logic [IW-1:0] i_calling_len,
    input wire logic [4*MAXD-1:0] i_calling_num,
    // call events
    input wire logic i_line_free,
    input wire logic i_call_accepted,
    input wire logic i_clear_req,
    input wire logic [7:0] i_prog_num,
    // link
    input wire logic i_user_bit,
    output logic o_link_bit,
    output logic o_link_sig,
    // status
    output logic o_busy,
    output logic o_through
);
    generate
        if (MAXD < 1 || MAXD > 24 || (1 << IW) <= MAXD + 4) begin : g_bad
            $error("icss_sequencer: MAXD or IW out of range");
        end
    endgenerate

    icss_pkg::icss_state_e st_q, st_d;
    logic [IW-1:0] idx_q, idx_d;
    logic clr_q, clr_d;
    logic acc_q, acc_d;
    logic free_q, free_d;
    logic pdone_q, pdone_d;
    logic [7:0] prog_q, prog_d;
    logic sup_q, sup_d, cdr_q, cdr_d, cgr_q, cgr_d;
    logic cda_q, cda_d, cga_q, cga_d, bef_q, bef_d, early_q, early_d;
    logic [15:0] code_q, code_d;
    logic [IW-1:0] cdl_q, cdl_d, cgl_q, cgl_d;
    logic [4*MAXD-1:0] cdn_q, cdn_d, cgn_q, cgn_d;
    logic busy_q, busy_d, thr_q, thr_d;

    icss_pkg::icss_seg_e seg;
    logic emitting;
    logic ld;
    logic mux_rdy;
    logic [7:0] chr;
    logic last;

    assign o_busy = busy_q;
    assign o_through = thr_q;

    // characters are generated locally from the latched call data [R09]
    icss_char_sel #(.MAXD(MAXD), .IW(IW)) u_char (
        .i_seg(seg),
        .i_idx(idx_q),
        .i_net_code(code_q),
        .i_suppress_cc(sup_q),
        .i_called_avail(cda_q),
        .i_called_len(cdl_q),
        .i_called_num(cdn_q),
        .i_calling_avail(cga_q),
        .i_calling_len(cgl_q),
        .i_calling_num(cgn_q),
        .i_prog_num(prog_q),
        .o_char(chr),
        .o_last(last)
    );

    icss_link_mux u_mux (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_ce(i_ce),
        .i_load(ld),
        .i_char(chr),
        .o_ready(mux_rdy),
        .i_user_bit(i_user_bit),
        .o_link_bit(o_link_bit),
        .o_link_sig(o_link_sig)
    );

    always_comb begin
        case (st_q)
            icss_pkg::ST_SEL: seg = icss_pkg::SEG_SEL;
            icss_pkg::ST_NETID: seg = icss_pkg::SEG_NETID;
            icss_pkg::ST_PROG1: seg = icss_pkg::SEG_PROG;
            icss_pkg::ST_PROGC: seg = icss_pkg::SEG_PROG;
            icss_pkg::ST_CALLED: seg = icss_pkg::SEG_CALLED;
            icss_pkg::ST_CALLING: seg = icss_pkg::SEG_CALLING;
            icss_pkg::ST_GO: seg = icss_pkg::SEG_GO;
            default: seg = icss_pkg::SEG_CLEAR;
        endcase
    end

    always_comb begin
        st_d = st_q;
        idx_d = idx_q;
        clr_d = clr_q;
        acc_d = acc_q;
        free_d = free_q;
        pdone_d = pdone_q;
        prog_d = prog_q;
        sup_d = sup_q;
        cdr_d = cdr_q;
        cgr_d = cgr_q;
        cda_d = cda_q;
        cga_d = cga_q;
        bef_d = bef_q;
        early_d = early_q;
        code_d = code_q;
        cdl_d = cdl_q;
        cgl_d = cgl_q;
        cdn_d = cdn_q;
        cgn_d = cgn_q;
        emitting = !(st_q == icss_pkg::ST_IDLE ||
                     st_q == icss_pkg::ST_WAIT ||
                     st_q == icss_pkg::ST_THRU);
        // a ready link is fed at once, so no gap opens in a block [R11]
        ld = emitting && mux_rdy;
        if (ld) begin
            if (last) begin
                idx_d = '0;
                case (st_q)
                    icss_pkg::ST_SEL: st_d = icss_pkg::ST_NETID; // [R10]
                    icss_pkg::ST_NETID: begin
                        if (cdr_q) begin
                            st_d = (clr_q && bef_q) ? icss_pkg::ST_PROG1 :
                                                      icss_pkg::ST_CALLED;
                        end else if (clr_q) begin
                            st_d = icss_pkg::ST_PROGC;
                        end else begin
                            st_d = cgr_q ? icss_pkg::ST_CALLING :
                                           icss_pkg::ST_WAIT;
                        end
                    end
                    icss_pkg::ST_PROG1: begin
                        pdone_d = 1'b1;
                        st_d = icss_pkg::ST_CALLED; // [R05]
                    end
                    icss_pkg::ST_CALLED: begin
                        if (clr_q) begin
                            st_d = pdone_q ? icss_pkg::ST_CLEAR :
                                             icss_pkg::ST_PROGC; // [R05]
                        end else begin
                            st_d = cgr_q ? icss_pkg::ST_CALLING :
                                           icss_pkg::ST_WAIT;
                        end
                    end
                    icss_pkg::ST_CALLING: st_d = icss_pkg::ST_WAIT;
                    icss_pkg::ST_GO: st_d = icss_pkg::ST_THRU;
                    icss_pkg::ST_PROGC: st_d = icss_pkg::ST_CLEAR;
                    default: st_d = icss_pkg::ST_IDLE;
                endcase
            end else begin
                idx_d = idx_q + 1'b1; // [R16]
            end
        end
        case (st_q)
            icss_pkg::ST_IDLE: begin
                if (i_call_req) begin
                    // selection starts on the very next cycle [R12]
                    st_d = icss_pkg::ST_SEL;
                    idx_d = '0;
                    clr_d = 1'b0;
                    acc_d = 1'b0;
                    free_d = 1'b0;
                    pdone_d = 1'b0;
                    sup_d = i_suppress_cc;
                    cdr_d = i_called_req;
                    cgr_d = i_calling_req;
                    cda_d = i_called_avail;
                    cga_d = i_calling_avail;
                    bef_d = i_prog_before;
                    early_d = i_early_go;
                    code_d = i_net_code;
                    cdl_d = i_called_len;
                    cgl_d = i_calling_len;
                    cdn_d = i_called_num;
                    cgn_d = i_calling_num;
                end
            end
            icss_pkg::ST_WAIT: begin
                if (clr_q) begin
                    st_d = icss_pkg::ST_PROGC; // [R06]
                end else if (acc_q || (early_q && free_q)) begin
                    st_d = icss_pkg::ST_GO; // [R04]
                end
            end
            icss_pkg::ST_THRU: begin
                if (clr_q) begin
                    st_d = icss_pkg::ST_CLEAR;
                end
            end
            default: begin
            end
        endcase
        // events are latched last so one arriving with a clear still counts
        if (st_q != icss_pkg::ST_IDLE) begin
            if (i_clear_req && !clr_q) begin
                clr_d = 1'b1;
                prog_d = i_prog_num;
            end
            if (i_call_accepted) begin
                acc_d = 1'b1;
            end
            if (i_line_free) begin
                free_d = 1'b1;
            end
        end
        busy_d = (st_d != icss_pkg::ST_IDLE);
        thr_d = (st_d == icss_pkg::ST_THRU);
    end

    // async reset drops any half-sent sequence and returns to idle [R15]
    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            st_q <= icss_pkg::ST_IDLE;
            idx_q <= '0;
            clr_q <= 1'b0;
            acc_q <= 1'b0;
            free_q <= 1'b0;
            pdone_q <= 1'b0;
            prog_q <= 8'h00;
            sup_q <= 1'b0;
            cdr_q <= 1'b0;
            cgr_q <= 1'b0;
            cda_q <= 1'b0;
            cga_q <= 1'b0;
            bef_q <= 1'b0;
            early_q <= 1'b0;
            code_q <= 16'h0000;
            cdl_q <= '0;
            cgl_q <= '0;
            cdn_q <= '0;
            cgn_q <= '0;
            busy_q <= 1'b0;
            thr_q <= 1'b0;
        end else if (i_ce) begin
            st_q <= st_d;
            idx_q <= idx_d;
            clr_q <= clr_d;
            acc_q <= acc_d;
            free_q <= free_d;
            pdone_q <= pdone_d;
            prog_q <= prog_d;
            sup_q <= sup_d;
            cdr_q <= cdr_d;
            cgr_q <= cgr_d;
            cda_q <= cda_d;
            cga_q <= cga_d;
            bef_q <= bef_d;
            early_q <= early_d;
            code_q <= code_d;
            cdl_q <= cdl_d;
            cgl_q <= cgl_d;
            cdn_q <= cdn_d;
            cgn_q <= cgn_d;
            busy_q <= busy_d;
            thr_q <= thr_d;
        end
    end

    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);

    chk_prog_shape: assert property (ld && seg == icss_pkg::SEG_PROG &&
        idx_q == '0 |-> chr == `ICSS_CH_PROG && !last)
        else $error("progress signal lacks its marker"); // [R01]
    chk_calling_term: assert property (ld && last &&
        seg == icss_pkg::SEG_CALLING |-> chr == `ICSS_CH_TERM12)
        else $error("calling identity not closed by 12"); // [R02]
    chk_called_alone: assert property (ld && !cda_q && idx_q == '0 &&
        seg == icss_pkg::SEG_CALLED |-> last && chr == `ICSS_CH_TERM12)
        else $error("unknown called identity not sent alone"); // [R03]
    chk_go_cause: assert property (i_ce && st_q == icss_pkg::ST_WAIT &&
        !clr_q && !acc_q && !(early_q && free_q)
        |=> st_q == icss_pkg::ST_WAIT)
        else $error("go signal without its cause"); // [R04]
    chk_clear_prog: assert property (i_ce && st_q == icss_pkg::ST_WAIT &&
        clr_q |=> st_q == icss_pkg::ST_PROGC)
        else $error("clear while waiting lacks progress"); // [R06]
    chk_suppress_cc: assert property (ld && sup_q && idx_q == '0 &&
        seg == icss_pkg::SEG_SEL |-> chr == icss_pkg::dchar(code_q[3:0]))
        else $error("network digit not sent alone"); // [R10]
    chk_sel_block: assert property (i_ce && st_q == icss_pkg::ST_SEL &&
        mux_rdy && !last |=> st_q == icss_pkg::ST_SEL && !mux_rdy)
        else $error("selection block interrupted"); // [R11]
    chk_early_start: assert property (i_ce && st_q == icss_pkg::ST_IDLE &&
        i_call_req |=> st_q == icss_pkg::ST_SEL && ld)
        else $error("onward selection delayed"); // [R12]
    chk_netid_lead: assert property (ld && seg == icss_pkg::SEG_NETID &&
        idx_q == '0 |-> chr == `ICSS_CH_NETID)
        else $error("network identity lacks its marker"); // [R14]
    chk_idle_quiet: assert property (st_q == icss_pkg::ST_IDLE |-> !ld)
        else $error("character sent while idle"); // [R15]
    chk_msd_first: assert property (ld && seg == icss_pkg::SEG_PROG &&
        idx_q == IW'(1) |-> chr == icss_pkg::dchar(prog_q[7:4]))
        else $error("progress digits out of order"); // [R16]
endmodule // icss_sequencer
`default_nettype wire

// *** bench/icss_far_end.sv ***
// far end model: gathers signalling characters off the shared link
`default_nettype none
module icss_far_end (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_ce,
    // link
    input wire logic i_link_bit,
    input wire logic i_link_sig,
    // answer request, reply after a chosen delay
    input wire logic i_ans_req,
    input wire logic [7:0] i_ans_delay,
    output logic o_accept
);
    timeunit 1ns;
    timeprecision 1ps;
    byte unsigned rx_q[$];
    logic [7:0] sh = 8'h00;
    int nb = 0;
    int cnt = -1;
    always @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            nb = 0;
            cnt = -1;
            rx_q.delete();
            o_accept <= 1'b0;
        end else begin
            // one bit per enabled cycle, lsb first, same path as data
            if (i_ce && i_link_sig) begin
                sh = {i_link_bit, sh[7:1]};
                nb++;
                if (nb == 8) begin
                    rx_q.push_back(sh);
                    nb = 0;
                end
            end
            o_accept <= (cnt == 0);
            if (i_ans_req)
                cnt = i_ans_delay;
            else if (cnt >= 0)
                cnt--;
        end
    end
endmodule // icss_far_end
`default_nettype wire

// *** bench/intl_call_signal_sequencer_tb.sv ***
// self-checking bench for the call signal sequencer
`default_nettype none
module intl_call_signal_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MAXD = 15;
    localparam int IW = 5;
    logic i_sys_clk = 1'b0, i_nrst = 1'b0, i_ce = 1'b1, i_call_req = 1'b0;
    logic i_suppress_cc = 1'b0, i_called_req = 1'b0, i_calling_req = 1'b0;
    logic i_called_avail = 1'b0, i_calling_avail = 1'b0, i_early_go = 1'b0;
    logic i_prog_before = 1'b0, i_line_free = 1'b0, i_clear_req = 1'b0;
    logic i_user_bit = 1'b0, ans_req = 1'b0, ce_rand = 1'b0, ubit_q = 1'b0;
    logic [15:0] i_net_code = 16'h0000;
    logic [IW-1:0] i_called_len = 5'h00, i_calling_len = 5'h00;
    logic [4*MAXD-1:0] i_called_num = '0, i_calling_num = '0;
    logic [7:0] i_prog_num = 8'h00, ans_delay = 8'h00;
    wire i_call_accepted;
    logic o_link_bit, o_link_sig, o_busy, o_through;
    int seed = 40;
    int n_fail = 0;
    int comparisons = 0;
    int live = 0;
    byte unsigned exp_q[$];
    logic [15:0] code;

    always #2 i_sys_clk = ~i_sys_clk;

    icss_sequencer #(.MAXD(MAXD), .IW(IW)) dut (.*);
    icss_far_end far (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_ce(i_ce),
        .i_link_bit(o_link_bit), .i_link_sig(o_link_sig),
        .i_ans_req(ans_req), .i_ans_delay(ans_delay),
        .o_accept(i_call_accepted));

    function automatic int rnd(input int m);
        return ($random(seed) & 32'h7fffffff) % m;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic final_report;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // user data and enable, all from the one seeded stream
    always @(posedge i_sys_clk) begin
        if (i_ce)
            ubit_q <= i_user_bit;
        live <= i_nrst ? live + 1 : 0;
        i_user_bit <= rnd(2);
        i_ce <= ce_rand ? (rnd(4) != 0) : 1'b1;
    end
    always @(negedge i_sys_clk) begin
        if (i_nrst && live > 1 && o_link_sig === 1'b0)
            check(o_link_bit, ubit_q);
    end

    function automatic void put_num(input int n, input logic [4*MAXD-1:0] v);
        for (int i = 0; i < n; i++)
            exp_q.push_back(8'h30 + v[4*MAXD-1-4*i -: 4]);
    endfunction

    function automatic void put_code(input logic only_net);
        for (int i = only_net ? 3 : 0; i < 4; i++)
            exp_q.push_back(8'h30 + code[15-4*i -: 4]);
    endfunction

    function automatic void put_prog();
        exp_q.push_back(8'h3a);
        put_num(2, {i_prog_num, 52'h0});
    endfunction

    function automatic void put_id(input logic cd, av, input int n,
                                   input logic [4*MAXD-1:0] v);
        if (av || !cd)
            put_code(1'b0);
        if (av)
            put_num(n, v);
        exp_q.push_back(8'h3c);
    endfunction

    task automatic wait_rx;
        for (int t = 0; t < 4000 && far.rx_q.size() < exp_q.size(); t++)
            @(posedge i_sys_clk);
        repeat (2) @(posedge i_sys_clk);
        check(far.rx_q.size(), exp_q.size());
        foreach (exp_q[i]) check(far.rx_q[i], exp_q[i]);
        exp_q.delete();
        far.rx_q.delete();
    endtask

    task automatic pulse(input int w);
        @(posedge i_sys_clk);
        i_clear_req <= w[1];
        i_line_free <= w[0];
        repeat (6) @(posedge i_sys_clk);
        i_clear_req <= 1'b0;
        i_line_free <= 1'b0;
    endtask

    task automatic run_call(input int k, input int ev);
        logic [4*MAXD-1:0] cdn, cgn;
        for (int i = 0; i < MAXD; i++) begin
            cdn[4*i +: 4] = 4'(rnd(10));
            cgn[4*i +: 4] = 4'(rnd(10));
        end
        for (int i = 0; i < 4; i++)
            code[4*i +: 4] = 4'(rnd(10));
        @(posedge i_sys_clk);
        ce_rand <= (k >= 9);
        i_suppress_cc <= k[0];
        i_called_req <= 1'(rnd(2));
        i_calling_req <= 1'(rnd(2));
        {i_called_avail, i_calling_avail, i_prog_before} <= 3'(rnd(8));
        i_early_go <= (ev == 1);
        i_called_len <= 5'(rnd(16));
        i_calling_len <= 5'(rnd(16));
        {i_called_num, i_calling_num, i_net_code} <= {cdn, cgn, code};
        i_prog_num <= {4'(rnd(10)), 4'(rnd(10))};
        i_call_req <= 1'b1;
        for (int t = 0; t < 50 && o_busy !== 1'b1; t++)
            @(posedge i_sys_clk);
        i_call_req <= 1'b0;
        if (ev == 4)
            return;
        put_code(i_suppress_cc);
        put_num(i_called_len, cdn);
        exp_q.push_back(8'h2b);
        exp_q.push_back(8'h3b);
        put_code(1'b0);
        if (ev == 3) begin
            pulse(2);
            if (!i_called_req || i_prog_before)
                put_prog();
            if (i_called_req)
                put_id(1, i_called_avail, i_called_len, cdn);
            if (i_called_req && !i_prog_before)
                put_prog();
        end else begin
            if (i_called_req)
                put_id(1, i_called_avail, i_called_len, cdn);
            if (i_calling_req)
                put_id(0, i_calling_avail, i_calling_len, cgn);
            wait_rx();
            if (ev == 2)
                put_prog();
            else
                exp_q.push_back(8'h3d);
            pulse(ev == 2 ? 2 : 1);
            if (ev == 0) begin
                repeat (40) @(posedge i_sys_clk);
                check(o_through, 1'b0);
                ans_req <= 1'b1;
                ans_delay <= 8'(rnd(50));
                @(posedge i_sys_clk);
                ans_req <= 1'b0;
            end
            if (ev != 2) begin
                wait_rx();
                check(o_through, 1'b1);
                pulse(2);
            end
        end
        exp_q.push_back(8'h3f);
        wait_rx();
        check(o_busy, 1'b0);
        $display("call %0d with case %0d done", k, ev);
    endtask

    initial begin
        repeat (20) @(posedge i_sys_clk);
        i_nrst <= 1'b1;
        for (int k = 0; k < 12; k++)
            run_call(k, k % 4);
        run_call(0, 4);
        repeat (40) @(posedge i_sys_clk);
        i_nrst <= 1'b0;
        @(posedge i_sys_clk);
        check({o_busy, o_link_sig, o_through}, 3'h0);
        repeat (4) @(posedge i_sys_clk);
        i_nrst <= 1'b1;
        repeat (60) @(posedge i_sys_clk);
        check(far.rx_q.size() + o_busy, 0);
        $display("reset test done");
        final_report();
    end

    initial begin
        #400000;
        n_fail++;
        final_report();
    end
endmodule // intl_call_signal_sequencer_tb
`default_nettype wire
